// ---- src/iossl_defs.svh ----
// Constants for the start/stop logic decoder.
// Assumes inclusion by bare name from src/.
`ifndef IOSSL_DEFS_SVH
`define IOSSL_DEFS_SVH
`define IOSSL_SEL_LEVEL 2'h0
`define IOSSL_SEL_THREE_WIRE 2'h1
`define IOSSL_SEL_EDGE 2'h2
`define IOSSL_SEL_START_REV 2'h3
`define IOSSL_IN_COUNT 6
`define IOSSL_B_CS1 0
`define IOSSL_B_CS2 1
`define IOSSL_B_CS3 2
`define IOSSL_B_KSTART 3
`define IOSSL_B_KSTOP 4
`define IOSSL_B_PERMIT 5
`define IOSSL_FILL_DEPTH 3
`endif

// ---- src/iossl_pkg.sv ----
// Types shared by the start/stop logic decoder.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package iossl_pkg;
  typedef enum logic [1:0] {
    IOSSL_STOPPED = 2'b00,
    IOSSL_FWD = 2'b01,
    IOSSL_REV = 2'b10
  } iossl_state_e;
endpackage
`default_nettype wire

// ---- src/iossl_sync_if.sv ----
// Interface carrying synchronised inputs and their edges.
// Assumes one clock domain.
`default_nettype none
interface iossl_sync_if #(parameter int N = 6);
  logic [N-1:0] level;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  modport src (output level, rise, fall);
  modport dst (input level, rise, fall);
endinterface
`default_nettype wire

// ---- src/iossl_sync.sv ----
// Two-flop synchroniser and edge detector per input bit.
// Assumes asynchronous pins and a synchronised active-low reset.
`include "iossl_defs.svh"
`default_nettype none
module iossl_sync #(
  parameter int N = 6
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [N-1:0] pins,
  iossl_sync_if.src sync
);
  logic [N-1:0] meta_q;
  logic [N-1:0] meta_d;
  logic [N-1:0] stable_q;
  logic [N-1:0] stable_d;
  logic [N-1:0] prev_q;
  logic [N-1:0] prev_d;
  logic [`IOSSL_FILL_DEPTH-1:0] fill_q;
  logic [`IOSSL_FILL_DEPTH-1:0] fill_d;

  // ----------------------------------------
  // Per-bit next values
  // ----------------------------------------
  always_comb begin
    meta_d = pins;
    stable_d = meta_q;
    prev_d = stable_q;
    fill_d = {fill_q[`IOSSL_FILL_DEPTH-2:0], 1'b1};
  end

  // Registers; the fill chain marks when prev holds a real pin sample
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      stable_q <= '0;
      prev_q <= '0;
      fill_q <= '0;
    end else begin
      meta_q <= meta_d;
      stable_q <= stable_d;
      prev_q <= prev_d;
      fill_q <= fill_d;
    end
  end

  // Edges from consecutive settled samples
  // Edges wait until the chain is full, so a contact already closed
  // at reset release never reads as a fresh start
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      assign sync.level[i] = stable_q[i];
      assign sync.rise[i] = stable_q[i] & ~prev_q[i] & fill_q[`IOSSL_FILL_DEPTH-1];
      assign sync.fall[i] = ~stable_q[i] & prev_q[i] & fill_q[`IOSSL_FILL_DEPTH-1];
    end
  endgenerate
endmodule
`default_nettype wire

// ---- src/iossl_top.sv ----
// Start/stop logic decoder for the I/O place A control inputs.
// Assumes asynchronous contacts and buttons; one 50 MHz clock.
`include "iossl_defs.svh"
`default_nettype none
module iossl_top
  import iossl_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic control_input_one,
  input wire logic control_input_two,
  input wire logic control_input_three,
  input wire logic keypad_start,
  input wire logic keypad_stop,
  input wire logic run_permit,
  input wire logic [1:0] io_place_a_start_logic_select,
  input wire logic keypad_stop_honour,
  input wire logic fault_reset,
  input wire logic io_control_enter,
  output logic run_cmd,
  output logic reverse_cmd,
  output logic zero_freq_cmd
);
  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_a_q;
  logic rst_b_q;
  logic rst_n;

  // Reset enters asynchronously but releases on two clock edges
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_a_q <= 1'b0;
      rst_b_q <= 1'b0;
    end else begin
      rst_a_q <= 1'b1;
      rst_b_q <= rst_a_q;
    end
  end
  assign rst_n = rst_b_q;

  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  iossl_sync_if #(.N(`IOSSL_IN_COUNT)) sif ();
  logic [`IOSSL_IN_COUNT-1:0] pins;

  // Pin bundle in fixed bit order
  always_comb begin
    pins = '0;
    pins[`IOSSL_B_CS1] = control_input_one;
    pins[`IOSSL_B_CS2] = control_input_two;
    pins[`IOSSL_B_CS3] = control_input_three;
    pins[`IOSSL_B_KSTART] = keypad_start;
    pins[`IOSSL_B_KSTOP] = keypad_stop;
    pins[`IOSSL_B_PERMIT] = run_permit;
  end

  iossl_sync #(.N(`IOSSL_IN_COUNT)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pins(pins),
    .sync(sif.src)
  );

  // Settled levels and edges
  logic cs1;
  logic cs2;
  logic cs3;
  logic cs1_rise;
  logic cs2_rise;
  logic cs3_rise;
  logic cs1_fall;
  logic cs2_fall;
  logic cs2_chg;
  logic kstart_rise;
  logic kstop_rise;
  logic permit;
  logic permit_fall;
  assign cs1 = sif.level[`IOSSL_B_CS1];
  assign cs2 = sif.level[`IOSSL_B_CS2];
  assign cs3 = sif.level[`IOSSL_B_CS3];
  assign cs1_rise = sif.rise[`IOSSL_B_CS1];
  assign cs2_rise = sif.rise[`IOSSL_B_CS2];
  assign cs3_rise = sif.rise[`IOSSL_B_CS3];
  assign cs1_fall = sif.fall[`IOSSL_B_CS1];
  assign cs2_fall = sif.fall[`IOSSL_B_CS2];
  assign cs2_chg = sif.rise[`IOSSL_B_CS2] | sif.fall[`IOSSL_B_CS2];
  assign kstart_rise = sif.rise[`IOSSL_B_KSTART];
  assign kstop_rise = sif.rise[`IOSSL_B_KSTOP];
  assign permit = sif.level[`IOSSL_B_PERMIT];
  assign permit_fall = sif.fall[`IOSSL_B_PERMIT];

  // Event strobes from same-clock logic, sampled once to form edges
  logic fault_reset_q;
  logic io_enter_q;
  logic fault_reset_d;
  logic io_enter_d;
  logic rearm_event;

  // ----------------------------------------
  // Run state machine
  // ----------------------------------------
  iossl_state_e state_q;
  iossl_state_e state_d;
  logic kp_stopped_q;
  logic kp_stopped_d;
  logic fwd_blocked_q;
  logic fwd_blocked_d;
  logic rev_blocked_q;
  logic rev_blocked_d;
  logic sel_edge;
  logic [1:0] sel;
  logic kstop_act;

  assign sel = io_place_a_start_logic_select;
  assign sel_edge = (sel == `IOSSL_SEL_THREE_WIRE) || (sel == `IOSSL_SEL_EDGE);
  assign rearm_event = (fault_reset & ~fault_reset_q) | (io_control_enter & ~io_enter_q);
  // Keypad stop is ignored unless honoured
  assign kstop_act = kstop_rise & keypad_stop_honour;

  // Next-state decode per selection
  always_comb begin
    state_d = state_q;
    kp_stopped_d = kp_stopped_q;
    fwd_blocked_d = fwd_blocked_q;
    rev_blocked_d = rev_blocked_q;
    fault_reset_d = fault_reset;
    io_enter_d = io_control_enter;
    // Opening a contact rearms its edge start
    if (!cs1) begin
      fwd_blocked_d = 1'b0;
    end
    if (sel == `IOSSL_SEL_THREE_WIRE ? !cs3 : !cs2) begin
      rev_blocked_d = 1'b0;
    end
    // Held contacts after a protective stop must open first
    if (rearm_event || permit_fall) begin
      fwd_blocked_d = sel_edge & cs1;
      rev_blocked_d = sel_edge & (sel == `IOSSL_SEL_THREE_WIRE ? cs3 : cs2);
    end
    case (sel)
      `IOSSL_SEL_LEVEL: begin
        // Level run; from standstill reverse needs a rising edge; first active direction keeps priority
        case (state_q)
          IOSSL_STOPPED: begin
            if (!kp_stopped_q && cs1) begin
              state_d = IOSSL_FWD;
            end else if (!kp_stopped_q && cs2_rise) begin
              state_d = IOSSL_REV;
            end
          end
          IOSSL_FWD: begin
            if (!cs1 && cs2) begin
              state_d = IOSSL_REV;
            end else if (!cs1) begin
              state_d = IOSSL_STOPPED;
            end
          end
          IOSSL_REV: begin
            if (!cs2 && cs1) begin
              state_d = IOSSL_FWD;
            end else if (!cs2) begin
              state_d = IOSSL_STOPPED;
            end
          end
          default: state_d = IOSSL_STOPPED;
        endcase
        // Keypad stop latches until keypad start with forward held, or until both direction contacts open
        if (kstart_rise && cs1) begin
          kp_stopped_d = 1'b0;
          state_d = IOSSL_FWD;
        end
        if (!cs1 && !cs2) begin
          kp_stopped_d = 1'b0;
        end
      end
      `IOSSL_SEL_THREE_WIRE: begin
        // Pulse control with active-low stop
        if (cs1_rise && !fwd_blocked_q && state_q != IOSSL_REV) begin
          state_d = IOSSL_FWD;
        end
        if (cs3_rise && !rev_blocked_q) begin
          state_d = IOSSL_REV;
        end
        if (!cs2) begin
          state_d = IOSSL_STOPPED;
        end
      end
      `IOSSL_SEL_EDGE: begin
        // Edge starts with first-set priority
        case (state_q)
          IOSSL_STOPPED: begin
            if (cs1_rise && !fwd_blocked_q) begin
              state_d = IOSSL_FWD;
            end else if (cs2_rise && !rev_blocked_q) begin
              state_d = IOSSL_REV;
            end
          end
          IOSSL_FWD: begin
            if (cs1_fall) begin
              state_d = cs2 ? IOSSL_REV : IOSSL_STOPPED;
            end
          end
          IOSSL_REV: begin
            if (cs2_fall) begin
              state_d = cs1 ? IOSSL_FWD : IOSSL_STOPPED;
            end
          end
          default: state_d = IOSSL_STOPPED;
        endcase
      end
      `IOSSL_SEL_START_REV: begin
        // Level start, reverse chooses direction
        if (!cs1) begin
          state_d = IOSSL_STOPPED;
          kp_stopped_d = 1'b0;
        end else if (!kp_stopped_q) begin
          state_d = cs2 ? IOSSL_REV : IOSSL_FWD;
        end else if (kstart_rise) begin
          kp_stopped_d = 1'b0;
          state_d = cs2 ? IOSSL_REV : IOSSL_FWD;
        end
        if (cs2_chg && state_q != IOSSL_STOPPED) begin
          state_d = cs2 ? IOSSL_REV : IOSSL_FWD;
        end
      end
      default: state_d = IOSSL_STOPPED;
    endcase
    // Keypad stop, honoured only when enabled
    if (kstop_act) begin
      state_d = IOSSL_STOPPED;
      kp_stopped_d = 1'b1;
      fwd_blocked_d = sel_edge & cs1;
      rev_blocked_d = sel_edge & (sel == `IOSSL_SEL_THREE_WIRE ? cs3 : cs2);
    end
    // Permit false forces standstill in every selection
    if (!permit) begin
      state_d = IOSSL_STOPPED;
      if (sel_edge) begin
        fwd_blocked_d = cs1;
        rev_blocked_d = (sel == `IOSSL_SEL_THREE_WIRE) ? cs3 : cs2;
      end
    end
  end

  // State registers; edge selections start blocked-free, inputs reset low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= IOSSL_STOPPED;
      kp_stopped_q <= 1'b0;
      fwd_blocked_q <= 1'b0;
      rev_blocked_q <= 1'b0;
      fault_reset_q <= 1'b0;
      io_enter_q <= 1'b0;
    end else begin
      state_q <= state_d;
      kp_stopped_q <= kp_stopped_d;
      fwd_blocked_q <= fwd_blocked_d;
      rev_blocked_q <= rev_blocked_d;
      fault_reset_q <= fault_reset_d;
      io_enter_q <= io_enter_d;
    end
  end

  // ----------------------------------------
  // Command outputs
  // ----------------------------------------
  logic run_q;
  logic rev_q;
  logic zero_q;
  logic run_d;
  logic rev_d;
  logic zero_d;

  // Outputs follow the registered state; direction held while stopped
  always_comb begin
    run_d = (state_d != IOSSL_STOPPED);
    rev_d = (state_d == IOSSL_REV) ? 1'b1 : (state_d == IOSSL_FWD) ? 1'b0 : rev_q;
    zero_d = (state_d == IOSSL_STOPPED);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 1'b0;
      rev_q <= 1'b0;
      zero_q <= 1'b1;
    end else begin
      run_q <= run_d;
      rev_q <= rev_d;
      zero_q <= zero_d;
    end
  end

  assign run_cmd = run_q;
  assign reverse_cmd = rev_q;
  assign zero_freq_cmd = zero_q;
endmodule
`default_nettype wire

// ---- test/iossl_chk.sv ----
// Concurrent checks on the ports of the start/stop decoder.
// Assumes a bind onto iossl_top; inputs settle 2 edges after a pin change.
`include "iossl_defs.svh"
`default_nettype none
module iossl_chk (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic control_input_one,
  input wire logic control_input_two,
  input wire logic control_input_three,
  input wire logic keypad_start,
  input wire logic keypad_stop,
  input wire logic run_permit,
  input wire logic [1:0] io_place_a_start_logic_select,
  input wire logic keypad_stop_honour,
  input wire logic fault_reset,
  input wire logic io_control_enter,
  input wire logic run_cmd,
  input wire logic reverse_cmd,
  input wire logic zero_freq_cmd
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ------------------------------------------------------------
  // Held input patterns, long enough to outlast the sync pipeline
  // ------------------------------------------------------------
  logic lvl;
  logic c1;
  logic c2;
  assign lvl = io_place_a_start_logic_select == `IOSSL_SEL_LEVEL;
  assign c1 = control_input_one;
  assign c2 = control_input_two;
  sequence s_fwd_held;
    (lvl && c1 && !c2 && run_permit && !keypad_stop_honour)[*7];
  endsequence
  sequence s_rev_held;
    (lvl && !c1 && c2 && run_permit && !keypad_stop_honour)[*7];
  endsequence
  property p_zero; zero_freq_cmd == !run_cmd; endproperty
  a_zero: assert property (p_zero) else $error("zero cmd not inverse of run");
  property p_permit; (!run_permit)[*7] |-> !run_cmd; endproperty
  a_permit: assert property (p_permit) else $error("run without permit");
  property p_idle; (lvl && !c1 && !c2)[*7] |-> !run_cmd; endproperty
  a_idle: assert property (p_idle) else $error("run with no direction input");
  property p_stop3;
    (io_place_a_start_logic_select == `IOSSL_SEL_THREE_WIRE && !c2)[*7] |-> !run_cmd;
  endproperty
  a_stop3: assert property (p_stop3) else $error("run with stop open");
  property p_fwd; s_fwd_held |-> run_cmd && !reverse_cmd; endproperty
  a_fwd: assert property (p_fwd) else $error("forward level not obeyed");
  property p_rev; s_rev_held |-> run_cmd && reverse_cmd; endproperty
  a_rev: assert property (p_rev) else $error("backward level not obeyed");
  property p_prio;
    (lvl && c1 && c2 && run_permit && run_cmd && !reverse_cmd)[*4] |=> !reverse_cmd;
  endproperty
  a_prio: assert property (p_prio) else $error("later input took priority");
  property p_edge;
    (io_place_a_start_logic_select == `IOSSL_SEL_EDGE && c1 && !c2 && !keypad_start
      && !run_cmd)[*7] |=> !run_cmd;
  endproperty
  a_edge: assert property (p_edge) else $error("start without rising edge");
endmodule
`default_nettype wire

// ---- test/iossl_far.sv ----
// Field contacts and keypad buttons facing the decoder.
// Assumes the bench sets the wanted positions; contacts move 2 ns after an edge.
`default_nettype none
module iossl_far (
  input wire logic clock,
  input wire logic [5:0] want,
  output logic c_one,
  output logic c_two,
  output logic c_three,
  output logic k_start,
  output logic k_stop,
  output logic permit
);
  timeunit 1ns;
  timeprecision 100ps;
  // Contacts and buttons follow the wanted positions one cycle late,
  // which stands for travel time; moves land off the sampling edge
  always @(posedge clock) begin
    #2 {permit, k_stop, k_start, c_three, c_two, c_one} = want;
  end
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench for the start/stop decoder, one task per selection.
// Assumes the contacts model drives the pins and the checker is bound.
`default_nettype none
module testbench;
  import iossl_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] sel = 2'h0;
  logic honour = 1'b0;
  logic f_rst = 1'b0;
  logic io_ent = 1'b0;
  logic c1, c2, c3, ks, kp, pm, run, rev, zero;
  // Wanted far-side positions: permit, stop, start, three, two, one
  logic [5:0] want = 6'h20;
  logic [2:0] outs;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  assign outs = {run, rev, zero};
  iossl_far i_far (.clock(clock), .want(want), .c_one(c1), .c_two(c2), .c_three(c3),
    .k_start(ks), .k_stop(kp), .permit(pm));
  iossl_top i_dut (.clock(clock), .reset_n(reset_n), .control_input_one(c1),
    .control_input_two(c2), .control_input_three(c3), .keypad_start(ks),
    .keypad_stop(kp), .run_permit(pm), .io_place_a_start_logic_select(sel),
    .keypad_stop_honour(honour), .fault_reset(f_rst), .io_control_enter(io_ent),
    .run_cmd(run), .reverse_cmd(rev), .zero_freq_cmd(zero));
  // ------------------------------------------------------------
  // Clock, watchdog and shared helpers
  // ------------------------------------------------------------
  initial begin
    forever #10 clock = ~clock;
  end
  // A hung scenario counts as a mismatch
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic w();
    repeat (8) @(posedge clock);
    #2;
  endtask
  // Compare a seen value against its expected value
  task automatic chk(input logic [2:0] seen, input logic [2:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Expected outputs from run and reverse; zero command is the inverse of run
  function automatic logic [2:0] ex(input logic [1:0] rv);
    return {rv, ~rv[1]};
  endfunction
  // Contacts as {three, two, one}; each level stays 3 cycles for the sync stages
  task automatic set_c(input logic [2:0] c);
    repeat (3) @(posedge clock);
    #2 want[2:0] = c;
  endtask
  task automatic set_p(input logic v);
    @(posedge clock);
    #2 want[5] = v;
  endtask
  // A button press is a 3 cycle pulse; stop high presses stop, else start
  task automatic push(input logic stop);
    @(posedge clock);
    #2 want[4:3] = {stop, !stop};
    repeat (3) @(posedge clock);
    #2 want[4:3] = 2'h0;
  endtask
  // Operator opens and recloses the start contact to rearm it
  task automatic reclose();
    set_c({want[2:1], 1'b0});
    set_c({want[2:1], 1'b1});
  endtask
  // Same-clock rearm strobes, one cycle wide
  task automatic rearm();
    @(posedge clock);
    #2 {f_rst, io_ent} = 2'h3;
    @(posedge clock);
    #2 {f_rst, io_ent} = 2'h0;
  endtask
  // Mid-run power cycle; whatever the contacts hold stays held
  task automatic reset_pulse();
    @(posedge clock);
    #2 reset_n = 1'b0;
    @(posedge clock);
    #2 reset_n = 1'b1;
  endtask
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_level();
    set_c(3'h1);
    w();
    chk(outs, ex(2'h2));
    set_c(3'h3);
    w();
    chk(outs, ex(2'h2));
    set_c(3'h2);
    w();
    chk(outs, ex(2'h3));
    set_c(3'h0);
    w();
    chk(outs, ex(2'h1));
    set_c(3'h2);
    w();
    chk(outs, ex(2'h3));
    set_c(3'h0);
    set_c(3'h1);
    w();
    chk(outs, ex(2'h2));
    set_p(1'b0);
    w();
    chk(outs, ex(2'h0));
    set_p(1'b1);
    w();
    chk(outs, ex(2'h2));
    push(1'b1);
    w();
    chk(outs, ex(2'h2));
    honour = 1'b1;
    push(1'b1);
    w();
    chk(outs, ex(2'h0));
    push(1'b0);
    w();
    chk(outs, ex(2'h2));
    push(1'b1);
    set_c(3'h0);
    push(1'b0);
    w();
    chk(outs, ex(2'h0));
    honour = 1'b0;
    $display("test level done");
  endtask
  task automatic t_three();
    sel = 2'h1;
    set_c(3'h2);
    w();
    chk(outs, ex(2'h0));
    set_c(3'h3);
    set_c(3'h2);
    w();
    chk(outs, ex(2'h2));
    set_c(3'h6);
    set_c(3'h2);
    w();
    chk(outs, ex(2'h3));
    set_c(3'h0);
    w();
    chk(outs, ex(2'h1));
    set_c(3'h2);
    set_c(3'h6);
    set_c(3'h2);
    w();
    chk(outs, ex(2'h3));
    set_p(1'b0);
    w();
    chk(outs, ex(2'h1));
    set_c(3'h3);
    set_c(3'h2);
    w();
    chk(outs, ex(2'h1));
    set_p(1'b1);
    w();
    chk(outs, ex(2'h1));
    set_c(3'h3);
    set_c(3'h2);
    w();
    chk(outs, ex(2'h2));
    set_c(3'h0);
    w();
    chk(outs, ex(2'h0));
    $display("test three wire done");
  endtask
  task automatic t_edge();
    sel = 2'h2;
    set_c(3'h1);
    w();
    chk(outs, ex(2'h2));
    set_c(3'h3);
    w();
    chk(outs, ex(2'h2));
    set_c(3'h2);
    w();
    chk(outs, ex(2'h3));
    set_c(3'h0);
    w();
    chk(outs, ex(2'h1));
    set_c(3'h1);
    w();
    chk(outs, ex(2'h2));
    set_p(1'b0);
    w();
    chk(outs, ex(2'h0));
    set_p(1'b1);
    w();
    chk(outs, ex(2'h0));
    rearm();
    w();
    chk(outs, ex(2'h0));
    reclose();
    w();
    chk(outs, ex(2'h2));
    reset_pulse();
    w();
    chk(outs, ex(2'h0));
    reclose();
    w();
    chk(outs, ex(2'h2));
    set_c(3'h0);
    w();
    chk(outs, ex(2'h0));
    $display("test edge done");
  endtask
  task automatic t_srev();
    sel = 2'h3;
    set_c(3'h1);
    w();
    chk(outs, ex(2'h2));
    set_c(3'h3);
    w();
    chk(outs, ex(2'h3));
    set_c(3'h1);
    w();
    chk(outs, ex(2'h2));
    set_c(3'h0);
    w();
    chk(outs, ex(2'h0));
    $display("test start reverse done");
  endtask
  // Main sequence: 6 cycles of reset, 3 settle cycles, then every selection
  initial begin
    repeat (6) @(posedge clock);
    #2 reset_n = 1'b1;
    repeat (3) @(posedge clock);
    t_level();
    t_three();
    t_edge();
    t_srev();
    stop_test();
  end
endmodule
bind iossl_top iossl_chk i_chk (.clock, .reset_n, .control_input_one, .control_input_two,
  .control_input_three, .keypad_start, .keypad_stop, .run_permit,
  .io_place_a_start_logic_select, .keypad_stop_honour, .fault_reset, .io_control_enter,
  .run_cmd, .reverse_cmd, .zero_freq_cmd);
`default_nettype wire
